/* verilog/ivl_input_voltage_limit.sv */
`timescale 1ns/1ns
`include "ivl_params.svh"
module ivl_input_voltage_limit #(
  parameter int UNIT_US = `IVL_UNIT_US_DEFAULT
)(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // command port
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_word,
  input  wire logic [7:0]  i_cmd,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  output logic             o_ack,
  output logic             o_nack,
  // sensing and control
  input  wire logic [15:0] i_vin,
  input  wire logic        i_vin_valid,
  input  wire logic        i_clear_fault,
  input  wire logic        i_cmd_on,
  // status and output control
  output logic             o_ov_warn,
  output logic             o_uv_warn,
  output logic             o_uv_fault,
  output logic             o_ratio_active,
  output logic             o_output_en,
  output logic [2:0]       o_state
);
  localparam int UNIT_CYC = (UNIT_US * `IVL_CLK_MHZ < 1) ? 1 : UNIT_US * `IVL_CLK_MHZ;
  localparam int CW = $clog2(UNIT_CYC * 128 + 1);
  if (UNIT_US < 1 || UNIT_US > 100000)
  begin : g_bad_unit
    $error("UNIT_US out of range");
  end

  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  logic rst_m_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire hit_ov   = (i_cmd == `IVL_CMD_OV_WARN);
  wire hit_uvw  = (i_cmd == `IVL_CMD_UV_WARN);
  wire hit_uvf  = (i_cmd == `IVL_CMD_UV_FAULT);
  wire hit_act  = (i_cmd == `IVL_CMD_UV_ACTION);
  wire hit_opt  = (i_cmd == `IVL_CMD_SPECIAL_OPTS);
  wire is_limit = hit_ov | hit_uvw | hit_uvf;
  wire size_ok  = is_limit ? i_word : ((hit_act | hit_opt) & ~i_word);
  wire legal    = size_ok & (is_limit | hit_act | hit_opt);
  wire acc      = i_wr | i_rd;
  wire wr_ok    = i_wr & legal;

  logic [15:0] ov_q;
  logic [15:0] uvw_q;
  logic [15:0] uvf_q;
  logic [7:0]  act_q;
  logic [7:0]  opt_q;
  wire         wr_ov  = wr_ok & hit_ov;
  wire         wr_uvw = wr_ok & hit_uvw;
  wire         wr_uvf = wr_ok & hit_uvf;
  wire         wr_act = wr_ok & hit_act;
  wire         wr_opt = wr_ok & hit_opt;
  wire         rd_ok  = i_rd & legal;

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ov_q <= `IVL_RST_OV_WARN;
    else if (wr_ov)
      ov_q <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      uvw_q <= `IVL_RST_UV_WARN;
    else if (wr_uvw)
      uvw_q <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      uvf_q <= `IVL_RST_UV_FAULT;
    else if (wr_uvf)
      uvf_q <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      act_q <= `IVL_RST_ACTION;
    else if (wr_act)
      act_q <= i_wdata[7:0];
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      opt_q <= `IVL_RST_OPTS;
    else if (wr_opt)
      opt_q <= i_wdata[7:0];
  end

  wire [15:0] rd_mux = hit_ov ? ov_q :
                       hit_uvw ? uvw_q :
                       hit_uvf ? uvf_q :
                       hit_act ? {8'h00, act_q} :
                       hit_opt ? {8'h00, opt_q} : 16'h0000;
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_rdata <= 16'h0000;
      o_ack   <= 1'b0;
      o_nack  <= 1'b0;
    end
    else
    begin
      o_rdata <= rd_ok ? rd_mux : o_rdata;
      o_ack   <= acc & legal;
      o_nack  <= acc & ~legal;
    end
  end

  // ----------------------------------------
  // limit comparison
  // ----------------------------------------
  wire ov_now  = i_vin > ov_q;
  wire uvw_now = i_vin < uvw_q;
  wire uvf_now = i_vin < uvf_q;
  logic ovw_q;
  logic uvwf_q;
  logic uvff_q;
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ovw_q  <= 1'b0;
      uvwf_q <= 1'b0;
      uvff_q <= 1'b0;
    end
    else if (i_vin_valid)
    begin
      ovw_q  <= ov_now;
      uvwf_q <= uvw_now;
      uvff_q <= uvf_now;
    end
  end
  assign o_ov_warn      = ovw_q;
  assign o_uv_warn      = uvwf_q;
  assign o_ratio_active = opt_q[`IVL_OPT_RATIO_BIT] & uvwf_q;

  // ----------------------------------------
  // fault response machine
  // ----------------------------------------
  function automatic logic [CW-1:0] delay_cycles(input logic [2:0] code);
    delay_cycles = CW'(UNIT_CYC << code);
  endfunction : delay_cycles

  function automatic ivl_pkg::ivl_state_t off_state(input logic [2:0] retry);
    off_state = (retry == 3'h0) ? ivl_pkg::IVL_ST_LATCHED : ivl_pkg::IVL_ST_WAIT;
  endfunction : off_state

  ivl_pkg::ivl_resp_t resp;
  assign resp = ivl_pkg::ivl_resp_t'(act_q[`IVL_ACT_RESP_HI:`IVL_ACT_RESP_LO]);
  wire [2:0]    retry_set = act_q[`IVL_ACT_RETRY_HI:`IVL_ACT_RETRY_LO];
  wire [CW-1:0] dly       = delay_cycles(act_q[`IVL_ACT_DELAY_HI:`IVL_ACT_DELAY_LO]);

  ivl_pkg::ivl_state_t st_q;
  ivl_pkg::ivl_state_t st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [2:0]    tries_q;
  logic [2:0]    tries_d;
  logic          sticky_q;
  logic          sticky_d;
  logic          on_q;
  wire           clear_ev = i_clear_fault | (i_cmd_on & ~on_q);
  wire           cnt_done = (cnt_q == '0);
  wire           can_retry = (retry_set == `IVL_RETRY_FOREVER) | (tries_q < retry_set);

  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_done ? cnt_q : cnt_q - CW'(1);
    tries_d  = tries_q;
    sticky_d = sticky_q | uvff_q;
    case (st_q)
      ivl_pkg::IVL_ST_RUN:
      begin
        if (uvff_q)
        begin
          if (resp == ivl_pkg::IVL_RESP_RIDE)
          begin
            st_d  = ivl_pkg::IVL_ST_RIDE;
            cnt_d = dly;
          end
          else if (resp == ivl_pkg::IVL_RESP_RETRY)
          begin
            st_d    = off_state(retry_set);
            cnt_d   = dly;
            tries_d = 3'h0;
          end
          else if (resp == ivl_pkg::IVL_RESP_LATCH)
            st_d = ivl_pkg::IVL_ST_LATCHED;
        end
      end
      ivl_pkg::IVL_ST_RIDE:
      begin
        if (!uvff_q)
          st_d = ivl_pkg::IVL_ST_RUN;
        else if (cnt_done)
        begin
          st_d    = off_state(retry_set);
          cnt_d   = dly;
          tries_d = 3'h0;
        end
      end
      ivl_pkg::IVL_ST_WAIT:
      begin
        if (cnt_done)
        begin
          st_d    = ivl_pkg::IVL_ST_RESTART;
          cnt_d   = dly;
          tries_d = (retry_set == `IVL_RETRY_FOREVER) ? tries_q : tries_q + 3'h1;
        end
      end
      ivl_pkg::IVL_ST_RESTART:
      begin
        if (!uvff_q)
          st_d = ivl_pkg::IVL_ST_RUN;
        else if (can_retry)
        begin
          st_d  = ivl_pkg::IVL_ST_WAIT;
          cnt_d = dly - CW'(2);
        end
        else
          st_d = ivl_pkg::IVL_ST_LATCHED;
      end
      ivl_pkg::IVL_ST_LATCHED:
      begin
        if (clear_ev)
          st_d = ivl_pkg::IVL_ST_RUN;
      end
      default:
        st_d = ivl_pkg::IVL_ST_RUN;
    endcase
    if (i_clear_fault & ~uvff_q)
      sticky_d = 1'b0;
    if (!i_cmd_on)
      st_d = ivl_pkg::IVL_ST_RUN;
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q    <= ivl_pkg::IVL_ST_RUN;
      cnt_q   <= '0;
      tries_q <= 3'h0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      tries_q <= tries_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sticky_q <= 1'b0;
      on_q     <= 1'b1;
    end
    else
    begin
      sticky_q <= sticky_d;
      on_q     <= i_cmd_on;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // output runs in run, ride-through and during a restart attempt
  assign o_output_en = i_cmd_on & ((st_q == ivl_pkg::IVL_ST_RUN) | (st_q == ivl_pkg::IVL_ST_RIDE)
                       | (st_q == ivl_pkg::IVL_ST_RESTART));
  assign o_uv_fault  = sticky_q;
  assign o_state     = st_q;
endmodule : ivl_input_voltage_limit

/* common/ivl_params.svh */
`ifndef IVL_PARAMS_SVH
`define IVL_PARAMS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define IVL_CMD_OV_WARN      8'h57
`define IVL_CMD_UV_WARN      8'h58
`define IVL_CMD_UV_FAULT     8'h59
`define IVL_CMD_UV_ACTION    8'h5a
`define IVL_CMD_SPECIAL_OPTS 8'he0
// ----------------------------------------
// field positions
// ----------------------------------------
`define IVL_ACT_RESP_HI      7
`define IVL_ACT_RESP_LO      6
`define IVL_ACT_RETRY_HI     5
`define IVL_ACT_RETRY_LO     3
`define IVL_ACT_DELAY_HI     2
`define IVL_ACT_DELAY_LO     0
`define IVL_OPT_RATIO_BIT    0
// ----------------------------------------
// reset values
// ----------------------------------------
`define IVL_RST_OV_WARN      16'h0000
`define IVL_RST_UV_WARN      16'h0000
`define IVL_RST_UV_FAULT     16'h0000
`define IVL_RST_ACTION       8'h00
`define IVL_RST_OPTS         8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define IVL_UNIT_US_DEFAULT  1000
`define IVL_CLK_MHZ          20
`define IVL_RETRY_FOREVER    3'h7
`endif

/* common/ivl_pkg.sv */
package ivl_pkg;
  typedef enum logic [1:0]
  {
    IVL_RESP_IGNORE  = 2'b00,
    IVL_RESP_RIDE    = 2'b01,
    IVL_RESP_RETRY   = 2'b10,
    IVL_RESP_LATCH   = 2'b11
  } ivl_resp_t;
  typedef enum logic [2:0]
  {
    IVL_ST_RUN      = 3'b000,
    IVL_ST_RIDE     = 3'b001,
    IVL_ST_WAIT     = 3'b010,
    IVL_ST_RESTART  = 3'b011,
    IVL_ST_LATCHED  = 3'b100
  } ivl_state_t;
endpackage : ivl_pkg

/* test/ivl_host_model.sv */
`timescale 1ns/1ns
module ivl_host_model (
  // answers in, requests out
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ack,
  input  wire logic        i_nack,
  output logic             o_wr = 1'b0,
  output logic             o_rd = 1'b0,
  output logic             o_word = 1'b0,
  output logic [7:0]       o_cmd = 8'h00,
  output logic [15:0]      o_wdata = 16'h0000
);
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic [1:0] s);
    @(negedge i_clk);
    o_wr = w;
    o_rd = !w;
    o_word = wd;
    o_cmd = c;
    o_wdata = wd ? d : {8'h00, d[7:0]};
    @(negedge i_clk);
    r = i_rdata;
    s = {i_ack, i_nack};
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~o_wdata;
  endtask : xfer
endmodule : ivl_host_model

/* test/ivl_input_voltage_limit_chk.sv */
`timescale 1ns/1ns
module ivl_input_voltage_limit_chk (
  // watched ports
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_word,
  input wire logic [7:0] i_cmd,
  input wire logic       i_cmd_on,
  input wire logic       o_ack,
  input wire logic       o_nack,
  input wire logic       o_uv_warn,
  input wire logic       o_ratio_active,
  input wire logic       o_output_en,
  input wire logic [2:0] o_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_enter; (o_state != 3'h2) ##1 (o_state == 3'h2); endsequence
  sequence s_off8; (o_state == 3'h2 && !o_output_en) [*8]; endsequence
  property p_ans; (i_wr || i_rd) |=> (o_ack != o_nack); endproperty
  property p_idle; !(i_wr || i_rd) |=> !o_ack && !o_nack; endproperty
  property p_size; (i_wr || i_rd) && (i_word == (i_cmd == 8'h5a || i_cmd == 8'he0)) |=> o_nack; endproperty
  property p_rat;
    (o_ratio_active |-> o_uv_warn) and
    ($changed(o_ratio_active) |-> $changed(o_uv_warn) || $past(i_wr && i_cmd == 8'he0));
  endproperty
  property p_wait; o_state == 3'h2 |-> !o_output_en; endproperty
  property p_lat; o_state == 3'h4 |-> !o_output_en; endproperty
  property p_one; o_state == 3'h3 |=> o_state != 3'h3; endproperty
  property p_off; !i_cmd_on |=> o_state == 3'h0; endproperty
  property p_wlen; disable iff (!i_rstn || !i_cmd_on) s_enter |-> s_off8; endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_size: assert property (p_size) else $error("wrong size accepted");
  a_rat: assert property (p_rat) else $error("ratio without warning");
  a_wait: assert property (p_wait) else $error("output on while waiting");
  a_lat: assert property (p_lat) else $error("output on while latched");
  a_one: assert property (p_one) else $error("restart longer than one cycle");
  a_off: assert property (p_off) else $error("command off ignored");
  a_wlen: assert property (p_wlen) else $error("wait too short");
endmodule : ivl_input_voltage_limit_chk

/* test/tb_ivl_input_voltage_limit.sv */
`timescale 1ns/1ns
module tb_ivl_input_voltage_limit;
  logic        i_clk, i_rstn, i_wr, i_rd, i_word, i_vin_valid, i_clear_fault, i_cmd_on;
  logic        o_ack, o_nack, o_ov_warn, o_uv_warn, o_uv_fault, o_ratio_active, o_output_en;
  logic [7:0]  i_cmd;
  logic [15:0] i_wdata, i_vin, o_rdata;
  logic [2:0]  o_state;
  int          err_total, tests_run, cyc;
  logic [7:0]  acts [11] = '{8'h40, 8'h48, 8'h80, 8'h89, 8'h91, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hc0, 8'hb8};
  int          nres [11] = '{0, 1, 0, 1, 2, 3, 4, 5, 6, 0, 99};
  logic [7:0]  cmds [3] = '{8'h57, 8'h58, 8'h59};
  logic [15:0] lims [3] = '{16'h0800, 16'h0200, 16'h0100};
  ivl_input_voltage_limit #(.UNIT_US(1)) uut (.i_clk, .i_rstn, .i_wr, .i_rd, .i_word, .i_cmd, .i_wdata,
    .o_rdata, .o_ack, .o_nack, .i_vin, .i_vin_valid, .i_clear_fault, .i_cmd_on, .o_ov_warn, .o_uv_warn,
    .o_uv_fault, .o_ratio_active, .o_output_en, .o_state);
  ivl_host_model host (.i_clk, .i_rdata(o_rdata), .i_ack(o_ack), .i_nack(o_nack), .o_wr(i_wr), .o_rd(i_rd),
    .o_word(i_word), .o_cmd(i_cmd), .o_wdata(i_wdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask : step
  task automatic acc(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d, input logic [1:0] e);
    logic [15:0] r;
    logic [1:0]  s;
    host.xfer(w, wd, c, d, r, s);
    chk(s, e);
    if (!w && e == 2'b10)
      chk(r, d);
  endtask : acc
  task automatic idle(input logic lat);
    i_vin = 16'h0300;
    step(3);
    i_clear_fault = 1'b1;
    step(1);
    i_clear_fault = 1'b0;
    step(2);
    chk(o_uv_fault, 1'b0);
    if (lat)
      chk(o_state, 3'h0);
    i_cmd_on = 1'b0;
    step(3);
    i_cmd_on = 1'b1;
    step(2);
  endtask : idle
  task automatic run(input logic [7:0] a, input int n);
    int c;
    int t0;
    int t1;
    c = 0;
    t0 = 0;
    t1 = 0;
    acc(1'b1, 1'b0, 8'h5a, {8'h00, a}, 2'b10);
    i_vin = 16'h0050;
    step(5);
    chk(o_output_en, a[7:6] == 2'b01);
    for (int k = 0; k < 3000 && o_state !== 3'h4; k++)
    begin
      step(1);
      if (o_state === 3'h3)
      begin
        t0 = t1;
        t1 = k;
        c++;
      end
    end
    chk(16'((n == 99 && c > 8) ? 99 : c), 16'(n));
    if (n >= 2)
      chk(16'(t1 - t0), 16'(20 << a[2:0]));
    idle(n != 99);
    $display("test action %h done", a);
  endtask : run
  // ----------------------------------------
  // clock, timeout and tests
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    i_rstn = 1'b0;
    i_vin = 16'h0300;
    i_vin_valid = 1'b0;
    i_clear_fault = 1'b0;
    i_cmd_on = 1'b1;
    step(4);
    i_rstn = 1'b1;
    i_vin_valid = 1'b1;
    step(3);
    acc(1'b0, 1'b0, 8'h5a, 16'h0000, 2'b10);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, 1'b1, cmds[i], 16'h0000, 2'b10);
      acc(1'b1, 1'b1, cmds[i], lims[i], 2'b10);
      acc(1'b0, 1'b1, cmds[i], lims[i], 2'b10);
    end
    acc(1'b1, 1'b0, 8'h57, 16'h00aa, 2'b01);
    acc(1'b1, 1'b1, 8'h5a, 16'h00c0, 2'b01);
    acc(1'b0, 1'b1, 8'h33, 16'h0000, 2'b01);
    acc(1'b0, 1'b1, 8'h57, 16'h0800, 2'b10);
    acc(1'b0, 1'b0, 8'h5a, 16'h0000, 2'b10);
    $display("test registers done");
    i_vin = 16'h0900;
    step(3);
    chk({o_ov_warn, o_uv_warn, o_uv_fault}, 3'b100);
    i_vin = 16'h0150;
    step(3);
    chk({o_ov_warn, o_uv_warn, o_uv_fault, o_ratio_active}, 4'b0100);
    acc(1'b1, 1'b0, 8'he0, 16'h0001, 2'b10);
    step(2);
    chk(o_ratio_active, 1'b1);
    i_vin = 16'h0050;
    step(8);
    chk({o_uv_fault, o_output_en}, 2'b11);
    idle(1'b1);
    $display("test sensing done");
    for (int i = 0; i < 11; i++)
      run(acts[i], nres[i]);
    acc(1'b1, 1'b0, 8'h5a, 16'h00c0, 2'b10);
    i_vin = 16'h0050;
    step(5);
    chk(o_state, 3'h4);
    i_rstn = 1'b0;
    step(2);
    chk(o_state, 3'h0);
    i_rstn = 1'b1;
    step(3);
    chk({o_output_en, o_uv_fault, o_ratio_active}, 3'b100);
    $display("test reset done");
    finish_test();
  end
endmodule : tb_ivl_input_voltage_limit
bind ivl_input_voltage_limit ivl_input_voltage_limit_chk u_chk (.i_clk, .i_rstn, .i_wr, .i_rd, .i_word,
  .i_cmd, .i_cmd_on, .o_ack, .o_nack, .o_uv_warn, .o_ratio_active, .o_output_en, .o_state);
